/* hw/pm1_regs.sv */
// one copy of the power-management event and control register blocks
`timescale 1ns/10ps
module pm1_regs
#(
	parameter logic [15:0] EVT_BASE    = 16'h0400,
	parameter logic [15:0] CNT_BASE    = 16'h0404,
	parameter logic [15:0] EVT_IMPL    = pm1_pkg::EVT_DEFINED_MASK,
	parameter logic [15:0] CNT_IMPL    = pm1_pkg::CNT_DEFINED_MASK,
	parameter bit          ROUTE_FIXED = 1'b0
)
(
	input  wire logic                 sys_clk_i,
	input  wire logic                 rst_i,
	input  wire pm1_pkg::pm1_io_req_s io_req_i,
	output logic [15:0]               io_rdata_o,
	input  wire logic                 timer_msb_i,
	input  wire logic                 global_lock_set_i,
	input  wire logic                 power_button_i,
	input  wire logic                 sleep_button_i,
	input  wire logic                 alarm_i,
	input  wire logic                 sleeping_i,
	input  wire logic                 deep_sleep_i,
	input  wire logic                 deep_sleep_alarm_capable_i,
	input  wire logic                 enter_working_i,
	input  wire logic                 route_set_i,
	input  wire logic                 route_clr_i,
	input  wire logic                 busmaster_req_i,
	input  wire logic                 cpu_in_c3_i,
	output logic                      os_event_interrupt_o,
	output logic                      firmware_mgmt_interrupt_o,
	output logic                      wakeup_o,
	output logic                      busmaster_wake_o,
	output logic                      global_lock_release_o,
	output logic                      sleep_entry_trigger_o,
	output logic [2:0]                sleep_type_code_o
);

	// only the bits this copy owns ever store or act
	localparam logic [15:0] EN_MASK  = EVT_IMPL & pm1_pkg::EVT_DEFINED_MASK;
	localparam logic [15:0] CNT_MASK = CNT_IMPL & pm1_pkg::CNT_DEFINED_MASK;

	function automatic logic [15:0] lane_merge
	(
		input logic [15:0] old_v,
		input logic [15:0] new_v,
		input logic [1:0]  be,
		input logic [15:0] mask
	);
		logic [15:0] m;
		m = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
		return m & mask;
	endfunction

	function automatic logic [15:0] lane_ones
	(
		input logic [15:0] v,
		input logic [1:0]  be
	);
		return {be[1] ? v[15:8] : 8'h00, be[0] ? v[7:0] : 8'h00};
	endfunction

	function automatic logic hit
	(
		input logic [15:0] addr,
		input logic [15:0] base,
		input logic [15:0] ofs
	);
		logic [15:0] loc;
		loc = base + ofs;
		return addr[15:1] == loc[15:1];
	endfunction

	logic        sts_hit;
	logic        en_hit;
	logic        cnt_hit;
	logic        en_wr;
	logic        cnt_wr;
	logic [15:0] wr_ones;
	logic [15:0] sts_q;
	logic [15:0] sts_set;
	logic [15:0] sts_clr;

	always_comb
	begin
		sts_hit = hit(io_req_i.addr, EVT_BASE, pm1_pkg::EVT_STS_OFS);
		en_hit  = hit(io_req_i.addr, EVT_BASE, pm1_pkg::EVT_EN_OFS);
		cnt_hit = hit(io_req_i.addr, CNT_BASE, pm1_pkg::CNT_OFS);
		en_wr   = io_req_i.wr & en_hit;
		cnt_wr  = io_req_i.wr & cnt_hit;
		wr_ones = lane_ones(io_req_i.wdata, io_req_i.be);
	end

	// edge history for the hardware event sources
	logic tmr_msb_reg;
	logic tmr_msb_next;
	logic pwr_btn_reg;
	logic pwr_btn_next;
	logic slp_btn_reg;
	logic slp_btn_next;
	logic alarm_reg;
	logic alarm_next;

	always_comb
	begin
		tmr_msb_next = timer_msb_i;
		pwr_btn_next = power_button_i;
		slp_btn_next = sleep_button_i;
		alarm_next   = alarm_i;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			tmr_msb_reg <= 1'b0;
			pwr_btn_reg <= 1'b0;
			slp_btn_reg <= 1'b0;
			alarm_reg   <= 1'b0;
		end
		else
		begin
			tmr_msb_reg <= tmr_msb_next;
			pwr_btn_reg <= pwr_btn_next;
			slp_btn_reg <= slp_btn_next;
			alarm_reg   <= alarm_next;
		end
	end

	// status bits live beside the enables so enables have something to gate
	always_comb
	begin
		sts_set = 16'h0000;
		sts_set[pm1_pkg::TMR_BIT]    = timer_msb_i ^ tmr_msb_reg;
		sts_set[pm1_pkg::GBL_BIT]    = global_lock_set_i;
		sts_set[pm1_pkg::PWRBTN_BIT] = power_button_i & ~pwr_btn_reg;
		sts_set[pm1_pkg::SLPBTN_BIT] = sleep_button_i & ~slp_btn_reg;
		// a deep-sleep alarm only counts when the platform says it can
		sts_set[pm1_pkg::RTC_BIT]    = alarm_i & ~alarm_reg
			& ~(sleeping_i & deep_sleep_i & ~deep_sleep_alarm_capable_i);
		sts_clr = (io_req_i.wr & sts_hit) ? wr_ones : 16'h0000;
	end

	pm1_sticky_bits
	#(
		.W         (16),
		.IMPL_MASK (EN_MASK)
	)
	u_status
	(
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.set_i     (sts_set),
		.clr_i     (sts_clr),
		.q_o       (sts_q)
	);

	// enable and control registers
	logic [15:0] en_reg;
	logic [15:0] en_next;
	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;
	logic        route_next;

	always_comb
	begin
		en_next = en_reg;
		if (en_wr)
			en_next = lane_merge(en_reg, io_req_i.wdata, io_req_i.be, EN_MASK);
		// entering working state with the route nailed to the OS starts clean
		if (ROUTE_FIXED && enter_working_i)
			en_next = pm1_pkg::EVT_EN_RESET;

		// software cannot move the route bit; only hardware inputs do
		route_next = cnt_reg[pm1_pkg::ROUTE_BIT];
		if (route_set_i)
			route_next = 1'b1;
		else if (route_clr_i)
			route_next = 1'b0;
		if (ROUTE_FIXED)
			route_next = 1'b1;

		cnt_next = cnt_reg;
		if (cnt_wr)
			cnt_next = lane_merge(cnt_reg, io_req_i.wdata, io_req_i.be,
				CNT_MASK & pm1_pkg::CNT_STORED_MASK);
		cnt_next[pm1_pkg::ROUTE_BIT] = route_next & CNT_MASK[pm1_pkg::ROUTE_BIT];
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			en_reg  <= pm1_pkg::EVT_EN_RESET;
			cnt_reg <= pm1_pkg::CNT_RESET;
		end
		else
		begin
			en_reg  <= en_next;
			cnt_reg <= cnt_next;
		end
	end

	// registered outputs and read data
	logic        os_int_next;
	logic        fw_int_next;
	logic        wake_next;
	logic        bm_wake_next;
	logic        gl_rel_next;
	logic        sleep_entry_trigger_next;
	logic [15:0] rdata_next;
	logic        pm_event;
	logic        os_int_reg;
	logic        fw_int_reg;
	logic        wake_reg;
	logic        bm_wake_reg;
	logic        gl_rel_reg;
	logic        sleep_entry_trigger_reg;
	logic [15:0] rdata_reg;

	always_comb
	begin
		// enabled status is a level, so the interrupt holds until status clears
		pm_event    = |(sts_q & en_reg & pm1_pkg::EVT_INT_MASK);
		os_int_next = pm_event & ~sleeping_i & cnt_reg[pm1_pkg::ROUTE_BIT];
		gl_rel_next = cnt_wr & wr_ones[pm1_pkg::GLREL_BIT] & CNT_MASK[pm1_pkg::GLREL_BIT];
		fw_int_next = (pm_event & ~sleeping_i & ~cnt_reg[pm1_pkg::ROUTE_BIT]) | gl_rel_next;
		wake_next   = sleeping_i & |(sts_q & en_reg & pm1_pkg::EVT_WAKE_MASK);
		bm_wake_next = busmaster_req_i & cpu_in_c3_i & cnt_reg[pm1_pkg::BMWAKE_BIT];
		sleep_entry_trigger_next = cnt_wr & wr_ones[pm1_pkg::SLPEN_BIT] & CNT_MASK[pm1_pkg::SLPEN_BIT];

		rdata_next = rdata_reg;
		if (io_req_i.rd)
		begin
			// write-only and reserved bits never reach the bus
			if (sts_hit)
				rdata_next = sts_q;
			else if (en_hit)
				rdata_next = en_reg & EN_MASK;
			else if (cnt_hit)
				rdata_next = cnt_reg & CNT_MASK & pm1_pkg::CNT_STORED_MASK;
			else
				rdata_next = 16'h0000;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			os_int_reg  <= 1'b0;
			fw_int_reg  <= 1'b0;
			wake_reg    <= 1'b0;
			bm_wake_reg <= 1'b0;
			gl_rel_reg  <= 1'b0;
			sleep_entry_trigger_reg  <= 1'b0;
			rdata_reg   <= 16'h0000;
		end
		else
		begin
			os_int_reg  <= os_int_next;
			fw_int_reg  <= fw_int_next;
			wake_reg    <= wake_next;
			bm_wake_reg <= bm_wake_next;
			gl_rel_reg  <= gl_rel_next;
			sleep_entry_trigger_reg  <= sleep_entry_trigger_next;
			rdata_reg   <= rdata_next;
		end
	end

	assign io_rdata_o                = rdata_reg;
	assign os_event_interrupt_o      = os_int_reg;
	assign firmware_mgmt_interrupt_o = fw_int_reg;
	assign wakeup_o                  = wake_reg;
	assign busmaster_wake_o          = bm_wake_reg;
	assign global_lock_release_o     = gl_rel_reg;
	assign sleep_entry_trigger_o     = sleep_entry_trigger_reg;
	assign sleep_type_code_o         = cnt_reg[pm1_pkg::SLPTYP_LSB +: pm1_pkg::SLPTYP_W];

endmodule

/* hw/pm1_pkg.sv */
// shared constants and carriers for the power-management enable/control register copy
package pm1_pkg;

	// register offsets, relative to each block's 32-bit aligned base
	localparam logic [15:0] EVT_STS_OFS = 16'h0000;
	localparam logic [15:0] EVT_EN_OFS  = 16'h0002;
	localparam logic [15:0] CNT_OFS     = 16'h0000;

	// event status / enable bit positions
	localparam int TMR_BIT    = 0;
	localparam int GBL_BIT    = 5;
	localparam int PWRBTN_BIT = 8;
	localparam int SLPBTN_BIT = 9;
	localparam int RTC_BIT    = 10;

	// control bit positions
	localparam int ROUTE_BIT    = 0;
	localparam int BMWAKE_BIT   = 1;
	localparam int GLREL_BIT    = 2;
	localparam int SLPTYP_LSB   = 10;
	localparam int SLPTYP_W     = 3;
	localparam int SLPEN_BIT    = 13;

	// bits that exist at all; everything else reads zero
	localparam logic [15:0] EVT_DEFINED_MASK = 16'h0721;
	localparam logic [15:0] CNT_STORED_MASK  = 16'h1C03;
	localparam logic [15:0] CNT_DEFINED_MASK = 16'h3C07;
	// enabled status that reaches an interrupt, and that reaches a wakeup
	localparam logic [15:0] EVT_INT_MASK     = 16'h0321;
	localparam logic [15:0] EVT_WAKE_MASK    = 16'h0700;

	localparam logic [15:0] EVT_EN_RESET = 16'h0000;
	localparam logic [15:0] CNT_RESET    = 16'h0000;
	localparam logic [15:0] STS_RESET    = 16'h0000;

	// one host I/O cycle, byte lanes on be
	typedef struct packed
	{
		logic [15:0] addr;
		logic        wr;
		logic        rd;
		logic [1:0]  be;
		logic [15:0] wdata;
	} pm1_io_req_s;

endpackage

/* hw/pm1_sticky_bits.sv */
// sticky status bits: hardware sets, software clears by writing one
`timescale 1ns/10ps
module pm1_sticky_bits
#(
	parameter int               W         = 16,
	parameter logic [W-1:0]     IMPL_MASK = '1
)
(
	input  wire logic          sys_clk_i,
	input  wire logic          rst_i,
	input  wire logic [W-1:0]  set_i,
	input  wire logic [W-1:0]  clr_i,
	output logic      [W-1:0]  q_o
);

	logic [W-1:0] q_reg;
	logic [W-1:0] q_next;

	genvar g;
	generate
		for (g = 0; g < W; g++)
		begin : g_bit
			// set wins over a clear in the same cycle so no event is lost
			always_comb
			begin
				q_next[g] = IMPL_MASK[g] & (set_i[g] | (q_reg[g] & ~clr_i[g]));
			end
		end
	endgenerate

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			q_reg <= '0;
		else
			q_reg <= q_next;
	end

	assign q_o = q_reg;

endmodule

/* testbench/pm1_regs_asserts.sv */
// port assertions for one register copy
`timescale 1ns/10ps
module pm1_regs_asserts
#(
	parameter logic [15:0] EVT_BASE = 16'h0400,
	parameter logic [15:0] CNT_BASE = 16'h0404
)
(
	input  wire logic                 sys_clk_i,
	input  wire logic                 rst_i,
	input  wire pm1_pkg::pm1_io_req_s io_req_i,
	input  wire logic [15:0]          io_rdata_o,
	input  wire logic                 busmaster_req_i,
	input  wire logic                 cpu_in_c3_i,
	input  wire logic                 os_event_interrupt_o,
	input  wire logic                 firmware_mgmt_interrupt_o,
	input  wire logic                 wakeup_o,
	input  wire logic                 busmaster_wake_o,
	input  wire logic                 global_lock_release_o,
	input  wire logic                 sleep_entry_trigger_o,
	input  wire logic [2:0]           sleep_type_code_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);
	logic        cw;
	logic        hit;
	logic        slp_wr;
	logic        rls_wr;
	logic        typ_wr;
	logic        en_rd;
	logic        cnt_rd;
	logic [14:0] a;
	assign a      = io_req_i.addr[15:1];
	assign cw     = io_req_i.wr && a == CNT_BASE[15:1];
	assign hit    = a inside {EVT_BASE[15:1], EVT_BASE[15:1] + 15'h0001, CNT_BASE[15:1]};
	assign slp_wr = cw && io_req_i.be[1] && io_req_i.wdata[13];
	assign rls_wr = cw && io_req_i.be[0] && io_req_i.wdata[2];
	assign typ_wr = cw && io_req_i.be[1];
	assign en_rd  = io_req_i.rd && a == EVT_BASE[15:1] + 15'h0001;
	assign cnt_rd = io_req_i.rd && a == CNT_BASE[15:1];
	a_sleep_entry_pulse: assert property (slp_wr |=> sleep_entry_trigger_o)
		else $error("sleep entry missing");
	a_sleep_entry_cause: assert property (sleep_entry_trigger_o |-> $past(slp_wr))
		else $error("sleep entry without write");
	a_sleep_type_load: assert property (typ_wr |=> sleep_type_code_o == $past(io_req_i.wdata[12:10]))
		else $error("sleep type not loaded");
	a_release_raises_fw: assert property (rls_wr |=> global_lock_release_o && firmware_mgmt_interrupt_o)
		else $error("lock release missing");
	a_release_cause: assert property (global_lock_release_o |-> $past(rls_wr))
		else $error("lock release without write");
	a_enable_reserved_zero: assert property (en_rd |=> (io_rdata_o & 16'hF8DE) == 16'h0000)
		else $error("enable reserved bits set");
	a_control_reserved_zero: assert property (cnt_rd |=> (io_rdata_o & 16'hE3FC) == 16'h0000)
		else $error("control reserved bits set");
	a_unmapped_reads_zero: assert property (io_req_i.rd && !hit |=> io_rdata_o == 16'h0000)
		else $error("unmapped read not zero");
	a_busmaster_wake_cause: assert property (busmaster_wake_o |-> $past(busmaster_req_i && cpu_in_c3_i))
		else $error("bus master wake without request");
	c_sleep: cover property (sleep_entry_trigger_o);
	c_wake: cover property (wakeup_o);
	c_os_int: cover property (os_event_interrupt_o);
endmodule
bind pm1_regs pm1_regs_asserts #(.EVT_BASE(EVT_BASE), .CNT_BASE(CNT_BASE)) u_asserts
(
	.sys_clk_i, .rst_i, .io_req_i, .io_rdata_o, .busmaster_req_i, .cpu_in_c3_i, .os_event_interrupt_o,
	.firmware_mgmt_interrupt_o, .wakeup_o, .busmaster_wake_o, .global_lock_release_o, .sleep_entry_trigger_o,
	.sleep_type_code_o
);

/* testbench/pm1_regs_tb.sv */
// self-checking bench for two register copies
`timescale 1ns/10ps
module pm1_regs_tb;
	logic                 sys_clk_i = 1'b0;
	logic                 rst_i = 1'b1;
	pm1_pkg::pm1_io_req_s io_req_i;
	logic [15:0]          io_rdata_o;
	logic [15:0]          outs;
	logic [15:0]          fix_rdata;
	logic                 timer_msb_i, global_lock_set_i, power_button_i, sleep_button_i, alarm_i;
	logic                 sleeping_i, deep_sleep_i, deep_sleep_alarm_capable_i, enter_working_i;
	logic                 route_set_i, route_clr_i, busmaster_req_i, cpu_in_c3_i;
	logic                 os_event_interrupt_o, firmware_mgmt_interrupt_o, wakeup_o, busmaster_wake_o;
	logic                 global_lock_release_o, sleep_entry_trigger_o;
	logic [2:0]           sleep_type_code_o;
	int                   errors = 0;
	int                   check_count = 0;
	localparam logic [15:0] ST = 16'h0400;
	localparam logic [15:0] EN = 16'h0402;
	localparam logic [15:0] CT = 16'h0404;
	always #10 sys_clk_i = ~sys_clk_i;
	// outputs packed: [8:6] type, os, fw, wake, bm, release, entry
	assign outs = {7'h00, sleep_type_code_o, os_event_interrupt_o, firmware_mgmt_interrupt_o,
		wakeup_o, busmaster_wake_o, global_lock_release_o, sleep_entry_trigger_o};
	pm1_regs dut
	(
		.sys_clk_i, .rst_i, .io_req_i, .io_rdata_o, .timer_msb_i, .global_lock_set_i, .power_button_i,
		.sleep_button_i, .alarm_i, .sleeping_i, .deep_sleep_i, .deep_sleep_alarm_capable_i, .enter_working_i,
		.route_set_i, .route_clr_i, .busmaster_req_i, .cpu_in_c3_i, .os_event_interrupt_o,
		.firmware_mgmt_interrupt_o, .wakeup_o, .busmaster_wake_o, .global_lock_release_o,
		.sleep_entry_trigger_o, .sleep_type_code_o
	);
	// second copy: fixed OS routing and only timer/global enables owned here
	pm1_regs
	#(
		.EVT_IMPL    (16'h0021),
		.ROUTE_FIXED (1'b1)
	)
	dut_fixed
	(
		.sys_clk_i, .rst_i, .io_req_i, .io_rdata_o (fix_rdata), .timer_msb_i, .global_lock_set_i, .power_button_i,
		.sleep_button_i, .alarm_i, .sleeping_i, .deep_sleep_i, .deep_sleep_alarm_capable_i, .enter_working_i,
		.route_set_i, .route_clr_i, .busmaster_req_i, .cpu_in_c3_i, .os_event_interrupt_o (),
		.firmware_mgmt_interrupt_o (), .wakeup_o (), .busmaster_wake_o (), .global_lock_release_o (),
		.sleep_entry_trigger_o (), .sleep_type_code_o ()
	);
	task chk(input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e)
		begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask
	task w(input logic [15:0] a, input logic [1:0] b, input logic [15:0] d);
		@(negedge sys_clk_i);
		io_req_i = '{addr: a, wr: 1'b1, rd: 1'b0, be: b, wdata: d};
		@(negedge sys_clk_i);
		io_req_i.wr = 1'b0;
	endtask
	task r(input logic [15:0] a, input logic [15:0] e);
		@(negedge sys_clk_i);
		io_req_i = '{addr: a, wr: 1'b0, rd: 1'b1, be: 2'b11, wdata: 16'h0000};
		@(negedge sys_clk_i);
		io_req_i.rd = 1'b0;
		chk(io_rdata_o, e);
	endtask
	task end_sim;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task s_reset;
		chk(outs, 16'h0000);
		r(EN, 16'h0000);
		r(CT, 16'h0000);
	endtask
	task s_enable;
		w(EN, 2'b11, 16'hFFFF);
		r(EN, 16'h0721);
		w(EN, 2'b01, 16'h0000);
		r(EN, 16'h0700);
		w(EN, 2'b10, 16'h0000);
		w(16'h0408, 2'b11, 16'hFFFF);
		r(16'h0408, 16'h0000);
		r(EN, 16'h0000);
	endtask
	task s_control;
		w(CT, 2'b11, 16'hFFFF);
		chk(outs, 16'h01D3);
		cyc(1);
		chk(outs, 16'h01C0);
		r(CT, 16'h1C02);
		for (int t = 0; t < 8; t++)
		begin
			w(CT, 2'b10, {2'b00, 1'b1, t[2:0], 10'h000});
			chk(outs, {7'h00, t[2:0], 6'h01});
		end
		busmaster_req_i = 1'b1;
		cpu_in_c3_i = 1'b1;
		cyc(2);
		chk(outs, 16'h01C4);
		w(CT, 2'b01, 16'h0000);
		cyc(2);
		chk(outs, 16'h01C0);
		busmaster_req_i = 1'b0;
	endtask
	task s_route;
		route_set_i = 1'b1;
		cyc(1);
		route_set_i = 1'b0;
		w(CT, 2'b01, 16'h0000);
		r(CT, 16'h1C01);
		power_button_i = 1'b1;
		cyc(3);
		chk(outs, 16'h01C0);
		r(ST, 16'h0100);
		power_button_i = 1'b0;
		w(EN, 2'b11, 16'h0100);
		cyc(2);
		chk(outs, 16'h01E0);
		route_clr_i = 1'b1;
		cyc(1);
		route_clr_i = 1'b0;
		cyc(2);
		chk(outs, 16'h01D0);
		w(ST, 2'b11, 16'h0100);
		r(ST, 16'h0000);
		w(EN, 2'b11, 16'h0000);
		route_set_i = 1'b1;
		cyc(1);
		route_set_i = 1'b0;
	endtask
	task s_timer;
		w(EN, 2'b11, 16'h0000);
		timer_msb_i = 1'b1;
		cyc(3);
		r(ST, 16'h0001);
		chk(outs, 16'h01C0);
		w(ST, 2'b01, 16'h0001);
		timer_msb_i = 1'b0;
		cyc(3);
		r(ST, 16'h0001);
		w(EN, 2'b01, 16'h0001);
		cyc(2);
		chk(outs, 16'h01E0);
		w(ST, 2'b01, 16'h0001);
		w(EN, 2'b01, 16'h0020);
		global_lock_set_i = 1'b1;
		cyc(1);
		global_lock_set_i = 1'b0;
		cyc(2);
		chk(outs, 16'h01E0);
	endtask
	task s_sleep;
		w(ST, 2'b01, 16'h0020);
		sleeping_i = 1'b1;
		w(EN, 2'b11, 16'h0600);
		sleep_button_i = 1'b1;
		cyc(3);
		chk(outs, 16'h01C8);
		sleep_button_i = 1'b0;
		w(ST, 2'b10, 16'h0200);
		deep_sleep_i = 1'b1;
		alarm_i = 1'b1;
		cyc(3);
		r(ST, 16'h0000);
		alarm_i = 1'b0;
		deep_sleep_alarm_capable_i = 1'b1;
		cyc(1);
		alarm_i = 1'b1;
		cyc(3);
		r(ST, 16'h0400);
		chk(outs, 16'h01C8);
	endtask
	task s_fixed;
		w(EN, 2'b11, 16'h0721);
		r(EN, 16'h0721);
		chk(fix_rdata, 16'h0021);
		enter_working_i = 1'b1;
		cyc(1);
		enter_working_i = 1'b0;
		r(EN, 16'h0721);
		chk(fix_rdata, 16'h0000);
	endtask
	initial
	begin
		#1000000;
		errors++;
		end_sim;
	end
	initial
	begin
		io_req_i = '0;
		{timer_msb_i, global_lock_set_i, power_button_i, sleep_button_i, alarm_i, sleeping_i, deep_sleep_i} = '0;
		{deep_sleep_alarm_capable_i, enter_working_i, route_set_i, route_clr_i, busmaster_req_i, cpu_in_c3_i} = '0;
		cyc(16);
		rst_i = 1'b0;
		s_reset;
		s_enable;
		s_control;
		s_route;
		s_timer;
		s_sleep;
		s_fixed;
		end_sim;
	end
endmodule
